//--- rtl/usbg_pkg.sv
// Package for serial port control, status and baud generator.
// Assumes a single system clock and AHB-Lite register access.
package usbg_pkg;
  localparam logic [7:0] TSC_OFFSET = 8'h00;
  localparam logic [7:0] RSC_OFFSET = 8'h04;
  localparam logic [7:0] BDIV_OFFSET = 8'h08;
  localparam logic [7:0] RXDATA_OFFSET = 8'h0c;
  localparam logic [7:0] TXDATA_OFFSET = 8'h10;
  localparam int CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int TX9_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT_BIT = 5;
  localparam int SYNC_BIT = 4;
  localparam int HS_BIT = 2;
  localparam int SHIFT_REG_EMPTY_FLAG_BIT = 1;
  localparam int TX_NINTH_BIT_BIT = 0;
  localparam int SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX9_BIT = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int FRAMING_ERROR_FLAG_BIT = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int RX_NINTH_BIT_BIT = 0;
  localparam logic [7:0] TSC_RESET = 8'h02;
  localparam logic [7:0] RSC_RESET = 8'h00;
  localparam logic [7:0] BDIV_RESET = 8'h00;
  localparam logic [5:0] PRE_LOW = 6'h3f;
  localparam logic [5:0] PRE_HIGH = 6'h0f;
  localparam logic [5:0] PRE_SYNC = 6'h03;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;

  typedef enum logic [1:0] {
    USBG_IDLE = 2'b00,
    USBG_START = 2'b01,
    USBG_DATA = 2'b10,
    USBG_STOP = 2'b11
  } usbg_state_t;

  typedef struct packed {
    logic clock_source_select;
    logic tx_nine_bit_select;
    logic transmit_enable_bit;
    logic sync_mode;
    logic high_speed_select;
    logic tx_ninth_bit;
  } usbg_tx_ctl_t;
endpackage

//--- rtl/usbg_top.sv
// Serial port: control/status registers, baud generator, simple tx/rx shifters.
// Assumes AHB-Lite single-word transfers and one system clock; pins are async.
// Function
// - Sync mode: clock source bit selects master (internal clock) or slave.
// - Transmit nine-bit select makes characters nine bits long.
// - Transmit enable gates transmitter; sync receive enables override it.
// - Mode select bit chooses synchronous or asynchronous operation.
// - Transmit control bit three always reads zero.
// - High-speed bit picks divide-by-16 in async; ignored in sync.
// - Shift-register empty flag reads one when idle; resets to one.
// - Ninth transmit bit is sent as ninth bit in nine-bit mode.
// - Serial port enable turns port on and owns both pins.
// - Receive nine-bit select makes received characters nine bits long.
// - Single receive starts one sync master reception; hardware clears it.
// - Continuous receive enables receiver; overrides single receive in sync.
// - Async nine-bit address detect loads only characters whose ninth bit is set.
// - Framing error flag refreshed only when the next valid character is loaded; data read leaves it.
// - Overrun error flag clears when continuous receive is cleared.
// - Baud generator is 8-bit free-running timer set by divisor.
// - Rates: clk/64(X+1), clk/16(X+1) async; clk/4(X+1) sync master.
// - Writing divisor clears baud timer immediately.
// - Async receive pin sampled three times, majority vote decides bit.
// - Baud generator runs whenever clocked; stops with clock in sleep.
`timescale 1ns/1ps
module usbg_top (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic rx_dt_in,
  input wire logic tx_ck_in,
  output logic rx_dt_out,
  output logic rx_dt_oe_out,
  output logic tx_ck_out,
  output logic tx_ck_oe_out
);
  // Bus registers
  logic wr_pend;
  logic [7:0] wr_addr;
  usbg_pkg::usbg_tx_ctl_t tx_ctl;
  logic serial_port_enable;
  logic rx_nine_bit_select;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic framing_error_flag;
  logic overrun_error_flag;
  logic rx_ninth_bit;
  logic [7:0] baud_divisor;
  logic [7:0] receive_data_register;
  logic rx_full;
  logic [7:0] tx_hold;
  logic tx_hold_full;
  logic shift_reg_empty_flag;

  wire addr_phase = hsel_in && hready_in && htrans_in == usbg_pkg::HTRANS_NONSEQ;
  wire rd_now = addr_phase && !hwrite_in;
  wire [7:0] a_now = haddr_in[7:0];
  wire wr_tsc = wr_pend && wr_addr == usbg_pkg::TSC_OFFSET;
  wire wr_rsc = wr_pend && wr_addr == usbg_pkg::RSC_OFFSET;
  wire wr_bdiv = wr_pend && wr_addr == usbg_pkg::BDIV_OFFSET;
  wire wr_txd = wr_pend && wr_addr == usbg_pkg::TXDATA_OFFSET;
  wire rd_rxd = rd_now && a_now == usbg_pkg::RXDATA_OFFSET;
  wire [7:0] wd = hwdata_in[7:0];

  wire sync_mode = tx_ctl.sync_mode;
  wire sync_master = sync_mode && tx_ctl.clock_source_select;
  wire sync_rx_on = sync_mode && (continuous_receive_enable ||
                    (sync_master && single_receive_enable));
  wire tx_allowed = serial_port_enable && tx_ctl.transmit_enable_bit && !sync_rx_on;
  wire rx_allowed = serial_port_enable && (sync_mode ? sync_rx_on
                    : continuous_receive_enable);

  wire [7:0] tsc_rd = {tx_ctl.clock_source_select, tx_ctl.tx_nine_bit_select,
                       tx_ctl.transmit_enable_bit, tx_ctl.sync_mode, 1'b0,
                       tx_ctl.high_speed_select, shift_reg_empty_flag, tx_ctl.tx_ninth_bit};
  wire [7:0] rsc_rd = {serial_port_enable, rx_nine_bit_select, single_receive_enable,
                       continuous_receive_enable, address_detect_enable,
                       framing_error_flag, overrun_error_flag, rx_ninth_bit};
  // Write still in its data phase is forwarded, so a read right after it sees the new value
  wire [7:0] tsc_fwd = {wd[usbg_pkg::CLOCK_SOURCE_SELECT_BIT], wd[usbg_pkg::TX9_BIT], wd[usbg_pkg::TRANSMIT_ENABLE_BIT_BIT],
                        wd[usbg_pkg::SYNC_BIT], 1'b0, wd[usbg_pkg::HS_BIT],
                        shift_reg_empty_flag, wd[usbg_pkg::TX_NINTH_BIT_BIT]};
  wire [7:0] rsc_fwd = {wd[usbg_pkg::SERIAL_PORT_ENABLE_BIT], wd[usbg_pkg::RX9_BIT], wd[usbg_pkg::SINGLE_RECEIVE_ENABLE_BIT],
                        wd[usbg_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT], wd[usbg_pkg::ADDRESS_DETECT_ENABLE_BIT], framing_error_flag,
                        overrun_error_flag && wd[usbg_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT], rx_ninth_bit};
  wire [7:0] rd_mux = (a_now == usbg_pkg::TSC_OFFSET) ? (wr_tsc ? tsc_fwd : tsc_rd) :
                      (a_now == usbg_pkg::RSC_OFFSET) ? (wr_rsc ? rsc_fwd : rsc_rd) :
                      (a_now == usbg_pkg::BDIV_OFFSET) ? (wr_bdiv ? wd : baud_divisor) :
                      (a_now == usbg_pkg::RXDATA_OFFSET) ? receive_data_register :
                      8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase && hwrite_in;
      wr_addr <= a_now;
      if (rd_now) begin
        hrdata_out <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  // Two-flop synchronisers
  logic [1:0] rx_sync;
  logic [1:0] ck_sync;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rx_sync <= 2'h3;
      ck_sync <= 2'h3;
    end else begin
      rx_sync <= {rx_sync[0], rx_dt_in};
      ck_sync <= {ck_sync[0], tx_ck_in};
    end
  end
  wire rx_pin = rx_sync[1];
  wire ck_pin = ck_sync[1];

  // Baud timer and prescaler
  logic [7:0] baud_timer;
  logic [5:0] pre_cnt;
  logic ck_prev;
  wire timer_tc = baud_timer == 8'h00;
  wire [5:0] pre_max = sync_mode ? usbg_pkg::PRE_SYNC :
                       (tx_ctl.high_speed_select ? usbg_pkg::PRE_HIGH : usbg_pkg::PRE_LOW);
  wire pre_wrap = timer_tc && pre_cnt >= pre_max;
  // One tick per bit period (master modes); per edge pair in slave
  wire slave_edge = sync_mode && !sync_master && ck_pin && !ck_prev;
  wire bit_tick = (sync_mode && !sync_master) ? slave_edge : pre_wrap;
  // Three sample points near mid bit in async mode
  wire [5:0] mid = {1'b0, pre_max[5:1]};
  // Receive frame counter, restarted at each start edge so samples land mid bit
  usbg_pkg::usbg_state_t rx_state;
  logic [5:0] rx_pre;
  wire rx_start = rx_state == usbg_pkg::USBG_IDLE && !rx_pin;
  wire rx_wrap = timer_tc && rx_pre >= pre_max;
  wire rx_tick = sync_mode ? bit_tick : rx_wrap;
  wire samp_tick = timer_tc && !sync_mode &&
                   (rx_pre == mid - 6'h01 || rx_pre == mid || rx_pre == mid + 6'h01);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || wr_bdiv) begin
      baud_timer <= usbg_pkg::BDIV_RESET;
      pre_cnt <= 6'h00;
    end else begin
      baud_timer <= timer_tc ? baud_divisor : baud_timer - 8'h01;
      if (timer_tc) begin
        pre_cnt <= pre_wrap ? 6'h00 : pre_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || rx_start) begin
      rx_pre <= 6'h00;
    end else if (timer_tc) begin
      rx_pre <= rx_wrap ? 6'h00 : rx_pre + 6'h01;
    end
  end

  // Majority vote of three samples
  logic [2:0] votes;
  logic [1:0] vote_cnt;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      votes <= 3'h7;
      vote_cnt <= 2'h0;
      ck_prev <= 1'b1;
    end else begin
      ck_prev <= ck_pin;
      if (samp_tick) begin
        votes <= {votes[1:0], rx_pin};
      end
    end
  end
  wire rx_bit = sync_mode ? rx_pin : ((votes[0] & votes[1]) | (votes[1] & votes[2]) |
                (votes[0] & votes[2]));

  // Transmitter
  usbg_pkg::usbg_state_t tx_state;
  logic [8:0] transmit_shift_register;
  logic [3:0] tx_cnt;
  logic [3:0] tx_len;
  logic tx_line;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_state <= usbg_pkg::USBG_IDLE;
      transmit_shift_register <= 9'h000;
      tx_cnt <= 4'h0;
      tx_len <= usbg_pkg::NBITS_8;
      tx_line <= 1'b1;
      shift_reg_empty_flag <= 1'b1;
      tx_hold_full <= 1'b0;
      tx_hold <= 8'h00;
    end else begin
      if (wr_txd) begin
        tx_hold <= wd;
        tx_hold_full <= 1'b1;
      end
      unique case (tx_state)
        usbg_pkg::USBG_IDLE: begin
          tx_line <= 1'b1;
          if (tx_allowed && tx_hold_full && bit_tick) begin
            transmit_shift_register <= {tx_ctl.tx_ninth_bit, tx_hold};
            tx_len <= tx_ctl.tx_nine_bit_select ? usbg_pkg::NBITS_9 : usbg_pkg::NBITS_8;
            tx_hold_full <= wr_txd;
            shift_reg_empty_flag <= 1'b0;
            tx_cnt <= 4'h0;
            tx_state <= sync_mode ? usbg_pkg::USBG_DATA : usbg_pkg::USBG_START;
            tx_line <= sync_mode ? tx_hold[0] : 1'b0;
          end
        end
        usbg_pkg::USBG_START: begin
          if (bit_tick) begin
            tx_line <= transmit_shift_register[0];
            tx_state <= usbg_pkg::USBG_DATA;
          end
        end
        usbg_pkg::USBG_DATA: begin
          if (bit_tick) begin
            transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt + 4'h1 == tx_len) begin
              tx_line <= 1'b1;
              tx_state <= sync_mode ? usbg_pkg::USBG_IDLE : usbg_pkg::USBG_STOP;
              shift_reg_empty_flag <= sync_mode;
            end else begin
              tx_line <= transmit_shift_register[1];
            end
          end
        end
        usbg_pkg::USBG_STOP: begin
          if (bit_tick) begin
            shift_reg_empty_flag <= 1'b1;
            tx_state <= usbg_pkg::USBG_IDLE;
          end
        end
      endcase
      if (!tx_allowed) begin
        tx_state <= usbg_pkg::USBG_IDLE;
        shift_reg_empty_flag <= 1'b1;
        tx_line <= 1'b1;
      end
    end
  end

  // Receiver; sync mode has no stop bit, so it completes one cycle after the last bit
  logic [8:0] receive_shift_register;
  logic [3:0] rx_cnt;
  logic [3:0] rx_len;
  wire rx_done = rx_state == usbg_pkg::USBG_STOP && (sync_mode || rx_tick);
  wire rx_keep = !sync_mode && rx_nine_bit_select && address_detect_enable ? receive_shift_register[8] : 1'b1;
  wire rx_load = rx_done && rx_keep && !overrun_error_flag;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rx_state <= usbg_pkg::USBG_IDLE;
      receive_shift_register <= 9'h000;
      rx_cnt <= 4'h0;
      rx_len <= usbg_pkg::NBITS_8;
    end else if (!rx_allowed) begin
      rx_state <= usbg_pkg::USBG_IDLE;
    end else begin
      unique case (rx_state)
        usbg_pkg::USBG_IDLE: begin
          rx_cnt <= 4'h0;
          rx_len <= rx_nine_bit_select ? usbg_pkg::NBITS_9 : usbg_pkg::NBITS_8;
          if (sync_mode || !rx_pin) begin
            rx_state <= sync_mode ? usbg_pkg::USBG_DATA : usbg_pkg::USBG_START;
          end
        end
        usbg_pkg::USBG_START: begin
          if (rx_tick) begin
            rx_state <= rx_bit ? usbg_pkg::USBG_IDLE : usbg_pkg::USBG_DATA;
          end
        end
        usbg_pkg::USBG_DATA: begin
          if (rx_tick) begin
            receive_shift_register <= rx_len == usbg_pkg::NBITS_9 ? {rx_bit, receive_shift_register[8:1]} : {1'b0, rx_bit, receive_shift_register[7:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt + 4'h1 == rx_len) begin
              rx_state <= usbg_pkg::USBG_STOP;
            end
          end
        end
        usbg_pkg::USBG_STOP: begin
          if (rx_done) begin
            rx_state <= usbg_pkg::USBG_IDLE;
          end
        end
      endcase
    end
  end
  wire stop_bad = !sync_mode && !rx_bit;

  // Control and status registers
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_ctl <= '0;
      {serial_port_enable, rx_nine_bit_select, single_receive_enable} <= 3'h0;
      {continuous_receive_enable, address_detect_enable} <= 2'h0;
      framing_error_flag <= 1'b0;
      overrun_error_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
      baud_divisor <= usbg_pkg::BDIV_RESET;
      receive_data_register <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (wr_tsc) begin
        tx_ctl <= {wd[usbg_pkg::CLOCK_SOURCE_SELECT_BIT], wd[usbg_pkg::TX9_BIT], wd[usbg_pkg::TRANSMIT_ENABLE_BIT_BIT],
                   wd[usbg_pkg::SYNC_BIT], wd[usbg_pkg::HS_BIT], wd[usbg_pkg::TX_NINTH_BIT_BIT]};
      end
      if (wr_bdiv) begin
        baud_divisor <= wd;
      end
      if (wr_rsc) begin
        serial_port_enable <= wd[usbg_pkg::SERIAL_PORT_ENABLE_BIT];
        rx_nine_bit_select <= wd[usbg_pkg::RX9_BIT];
        single_receive_enable <= wd[usbg_pkg::SINGLE_RECEIVE_ENABLE_BIT];
        continuous_receive_enable <= wd[usbg_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
        address_detect_enable <= wd[usbg_pkg::ADDRESS_DETECT_ENABLE_BIT];
      end
      if (rd_rxd) begin
        rx_full <= 1'b0;
      end
      if (rx_done && sync_master && !continuous_receive_enable) begin
        single_receive_enable <= 1'b0;
      end
      if (rx_load && !(rx_full && !rd_rxd)) begin
        receive_data_register <= receive_shift_register[7:0];
        rx_ninth_bit <= receive_shift_register[8];
        framing_error_flag <= stop_bad;
        rx_full <= 1'b1;
      end
      if (wr_rsc && !wd[usbg_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
        overrun_error_flag <= 1'b0;
      end
      if (rx_done && rx_keep && rx_full && !rd_rxd) begin
        overrun_error_flag <= 1'b1; // Set wins over clear
      end
    end
  end

  // Pins
  wire ck_drive = serial_port_enable && sync_master;
  wire ck_level = !(sync_master && pre_cnt > {1'b0, pre_max[5:1]});
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_ck_out <= 1'b1;
      tx_ck_oe_out <= 1'b0;
      rx_dt_out <= 1'b1;
      rx_dt_oe_out <= 1'b0;
    end else begin
      tx_ck_out <= sync_mode ? ck_level : tx_line;
      tx_ck_oe_out <= serial_port_enable && (!sync_mode ? tx_allowed : ck_drive);
      rx_dt_out <= tx_line;
      rx_dt_oe_out <= serial_port_enable && sync_mode && tx_allowed;
    end
  end
endmodule // usbg_top

//--- tb/usbg_checker.sv
// Checker for usbg_top: bus answers and pin enables.
// Assumes hready_in is fed from hreadyout_out; bound below.
`timescale 1ns/1ps
module usbg_checker (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic rx_dt_oe_out,
  input wire logic tx_ck_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic ap_v;
  logic ap_w;
  logic [7:0] ap_a;
  logic serial_port_enable_m;
  logic sync_m;
  logic continuous_receive_enable_m;
  logic tx_used;
  wire take = hsel_in && hready_in && htrans_in == usbg_pkg::HTRANS_NONSEQ;
  wire wr_dp = hready_in && ap_v && ap_w;
  wire wr_tsc = wr_dp && ap_a == usbg_pkg::TSC_OFFSET;
  wire wr_rsc = wr_dp && ap_a == usbg_pkg::RSC_OFFSET;
  wire wr_txd = wr_dp && ap_a == usbg_pkg::TXDATA_OFFSET;
  // Address phase capture
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ap_v <= 1'b0;
    end else if (hready_in) begin
      ap_v <= take;
    end
    if (hready_in) begin
      ap_w <= hwrite_in;
      ap_a <= haddr_in[7:0];
    end
  end
  // Mirror of control bits written by software
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      {serial_port_enable_m, sync_m, continuous_receive_enable_m, tx_used} <= 4'h0;
    end else begin
      if (wr_rsc) begin
        serial_port_enable_m <= hwdata_in[usbg_pkg::SERIAL_PORT_ENABLE_BIT];
        continuous_receive_enable_m <= hwdata_in[usbg_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT];
      end
      if (wr_tsc) begin
        sync_m <= hwdata_in[usbg_pkg::SYNC_BIT];
      end
      if (wr_txd) begin
        tx_used <= 1'b1;
      end
    end
  end
  sequence s_rd(logic [7:0] a);
    take && !hwrite_in && haddr_in == {24'h0, a};
  endsequence
  chk_ready_on: assert property (!$past(sys_rst_in) |-> hreadyout_out)
    else $error("bus not ready after reset");
  chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=>
    !hreadyout_out && !tx_ck_oe_out && !rx_dt_oe_out)
    else $error("outputs not quiet in reset");
  chk_bit3_zero: assert property (s_rd(usbg_pkg::TSC_OFFSET) |=>
    !hrdata_out[3] && hrdata_out[31:8] == 24'h0)
    else $error("unused control bit read as one");
  chk_unmapped_zero: assert property (take && !hwrite_in && haddr_in > 32'h10
    |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_idle_empty: assert property (s_rd(usbg_pkg::TSC_OFFSET) ##1 !tx_used
    |-> hrdata_out[usbg_pkg::SHIFT_REG_EMPTY_FLAG_BIT])
    else $error("shift register not empty before any send");
  chk_overrun_error_flag_clear: assert property (s_rd(usbg_pkg::RSC_OFFSET) ##1 !continuous_receive_enable_m
    |-> !hrdata_out[usbg_pkg::OVERRUN_ERROR_FLAG_BIT])
    else $error("overrun kept with receiver off");
  chk_port_off: assert property (!serial_port_enable_m && !$past(serial_port_enable_m)
    |-> !tx_ck_oe_out && !rx_dt_oe_out)
    else $error("pin driven with port off");
  chk_async_no_dt: assert property (!sync_m && !$past(sync_m)
    |-> !rx_dt_oe_out)
    else $error("data pin driven in async mode");
endmodule // usbg_checker
bind usbg_top usbg_checker u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .rx_dt_oe_out(rx_dt_oe_out), .tx_ck_oe_out(tx_ck_oe_out));

//--- tb/usbg_peer.sv
// Remote serial peer: sends and receives async characters.
// Assumes line_in is the resolved transmit wire with pull-up.
`timescale 1ns/1ps
module usbg_peer (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // Idle bit, start, data lsb first, stop level chosen by caller
  task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stop);
    line_out <= 1'b1;
    repeat (bt) @(posedge clk_in);
    line_out <= 1'b0;
    repeat (bt) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (bt) @(posedge clk_in);
    end
    line_out <= stop;
    repeat (bt) @(posedge clk_in);
    line_out <= 1'b1;
    // Trailing idle lets the receiver finish before the caller reads
    repeat (bt) @(posedge clk_in);
  endtask
  // Bit time taken from start bit width
  task automatic recv(output logic [8:0] d, output int w, input int nb);
    int n;
    n = 0;
    w = 0;
    d = 9'h0;
    while (line_in !== 1'b0 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    while (line_in === 1'b0 && w < 5000) begin
      @(posedge clk_in);
      w++;
    end
    repeat (w / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      d[i] = line_in;
      repeat (w) @(posedge clk_in);
    end
  endtask
endmodule // usbg_peer

//--- tb/usbg_tb.sv
// Testbench for usbg_top: registers over AHB-Lite, serial traffic via peer.
// Assumes the bound checker and a pull-up on the transmit wire.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic rx_dt_out, rx_dt_oe, tx_ck_out, tx_ck_oe, peer_line;
  logic [8:0] d9;
  int w;
  int n;
  int bad_count = 0;
  int checks_done = 0;
  wire logic tx_wire = tx_ck_oe ? tx_ck_out : 1'b1;
  wire logic rx_wire = rx_dt_oe ? rx_dt_out : peer_line;
  always #20 ref_clk = ~ref_clk;
  usbg_top dut (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(), .rx_dt_in(rx_wire), .tx_ck_in(tx_wire),
    .rx_dt_out(rx_dt_out), .rx_dt_oe_out(rx_dt_oe), .tx_ck_out(tx_ck_out),
    .tx_ck_oe_out(tx_ck_oe));
  usbg_peer peer (.clk_in(ref_clk), .line_in(tx_wire), .line_out(peer_line));
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      bad_count++;
      results();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] wd,
    output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= usbg_pkg::HTRANS_NONSEQ;
    hwrite <= wr_en;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    bus(a, 1'b1, wd, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    `CHK(r, e);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    for (int k = 0; k < 200; k++) begin
      bus(a, 1'b0, 32'h0, r);
      if (r[b] === v) return;
    end
    bad_count++;
    results();
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rchk(usbg_pkg::TSC_OFFSET, 32'h02);
    rchk(usbg_pkg::RSC_OFFSET, 32'h00);
    rchk(usbg_pkg::BDIV_OFFSET, 32'h00);
    rchk(8'h20, 32'h0);
    wr(usbg_pkg::TSC_OFFSET, 32'hff);
    rchk(usbg_pkg::TSC_OFFSET, 32'hf7);
    wr(usbg_pkg::TSC_OFFSET, 32'h00);
    wr(usbg_pkg::BDIV_OFFSET, 32'h5a);
    rchk(usbg_pkg::BDIV_OFFSET, 32'h5a);
    wr(usbg_pkg::RSC_OFFSET, 32'h80);
    // High speed x1, low speed x1, high speed x3
    for (int i = 0; i < 3; i++) begin
      wr(usbg_pkg::BDIV_OFFSET, (i == 2) ? 32'h2 : 32'h0);
      wr(usbg_pkg::TSC_OFFSET, (i == 1) ? 32'h20 : 32'h24);
      poll(usbg_pkg::TSC_OFFSET, usbg_pkg::SHIFT_REG_EMPTY_FLAG_BIT, 1'b1);
      wr(usbg_pkg::TXDATA_OFFSET, 32'ha5);
      fork
        peer.recv(d9, w, 8);
        begin
          n = 0;
          while (tx_wire !== 1'b0 && n < 5000) begin
            @(posedge ref_clk);
            n++;
          end
          if (n >= 5000) begin
            bad_count++;
            results();
          end
          rchk(usbg_pkg::TSC_OFFSET, (i == 1) ? 32'h20 : 32'h24);
        end
      join
      `CHK(d9[7:0], 8'ha5);
      `CHK(w, ((i == 1) ? 64 : 16) * ((i == 2) ? 3 : 1));
    end
    wr(usbg_pkg::TSC_OFFSET, 32'h65);
    poll(usbg_pkg::TSC_OFFSET, usbg_pkg::SHIFT_REG_EMPTY_FLAG_BIT, 1'b1);
    wr(usbg_pkg::TXDATA_OFFSET, 32'h3d);
    peer.recv(d9, w, 9);
    `CHK(d9, 9'h13d);
    `CHK(w, 48);
    wr(usbg_pkg::BDIV_OFFSET, 32'h0);
    wr(usbg_pkg::TSC_OFFSET, 32'h04);
    wr(usbg_pkg::RSC_OFFSET, 32'h90);
    peer.send(9'h0c3, 8, 16, 1'b1);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'hc3);
    rchk(usbg_pkg::RSC_OFFSET, 32'h90);
    peer.send(9'h055, 8, 16, 1'b0);
    rchk(usbg_pkg::RSC_OFFSET, 32'h94);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'h55);
    peer.send(9'h066, 8, 16, 1'b1);
    rchk(usbg_pkg::RSC_OFFSET, 32'h90);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'h66);
    peer.send(9'h001, 8, 16, 1'b1);
    peer.send(9'h002, 8, 16, 1'b1);
    rchk(usbg_pkg::RSC_OFFSET, 32'h92);
    wr(usbg_pkg::RSC_OFFSET, 32'h80);
    rchk(usbg_pkg::RSC_OFFSET, 32'h80);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'h01);
    wr(usbg_pkg::RSC_OFFSET, 32'hd8);
    peer.send(9'h011, 9, 16, 1'b1);
    peer.send(9'h122, 9, 16, 1'b1);
    rchk(usbg_pkg::RSC_OFFSET, 32'hd9);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'h22);
    wr(usbg_pkg::TSC_OFFSET, 32'h90);
    wr(usbg_pkg::RSC_OFFSET, 32'ha0);
    poll(usbg_pkg::RSC_OFFSET, usbg_pkg::SINGLE_RECEIVE_ENABLE_BIT, 1'b0);
    rchk(usbg_pkg::RXDATA_OFFSET, 32'hff);
    results();
  end
endmodule // testbench
